// File: hw/sxi_pkg.sv
// constants and types for the system exception and interrupt status block
`default_nettype none
package sxi_pkg;
   // register addresses, byte addresses of the documented map
   localparam logic [23:0] SXI_ADDR_EXC_HIGH  = 24'hffe020;
   localparam logic [23:0] SXI_ADDR_EXC_LOW   = 24'hffe021;
   localparam logic [23:0] SXI_ADDR_LAST_VEC  = 24'hffe023;
   localparam logic [23:0] SXI_ADDR_PEND      = 24'hffe030;
   localparam logic [23:0] SXI_ADDR_PEND_SET  = 24'hffe031;
   localparam int          SXI_ADDR_W         = 24;
   // reset values
   localparam logic [7:0]  SXI_EXC_RESET      = 8'h00;
   localparam logic [7:0]  SXI_LAST_RESET     = 8'h04;
   localparam logic [7:0]  SXI_PEND_RESET     = 8'h00;
   // field layout of the high status byte: bits 7..3 used
   localparam int          SXI_HIGH_LSB       = 3;
   localparam int          SXI_HIGH_N         = 5;
   // field layout of the low status byte: bits 2..0 used
   localparam int          SXI_LOW_N          = 3;
   // vector field of the last-serviced register sits in bits 6..2
   localparam int          SXI_VEC_LSB        = 2;
   localparam int          SXI_VEC_W          = 5;
   // shared exception vector address
   localparam logic [23:0] SXI_EXC_VECTOR     = 24'h000008;
   // largest legal quotient before divide overflow
   localparam logic [31:0] SXI_QUOT_MAX       = 32'h0fffffff;
   // exception source index inside the 8-bit combined flag vector
   localparam int          SXI_IDX_ILL        = 3;
endpackage : sxi_pkg
`default_nettype wire

// File: hw/sxi_w1c_bits.sv
// bank of sticky flags: set by hardware, cleared by write-one
`timescale 1ns/1ps
`default_nettype none
module sxi_w1c_bits #(
   parameter int          WIDTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic [WIDTH-1:0] clr_in,
   output logic      [WIDTH-1:0] flag_out
);
   // one flag per bit; a set in the clear cycle wins so no event is lost
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic flag_q;
         logic flag_d;
         assign flag_d = set_in[i] | (flag_q & ~clr_in[i]);
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               flag_q <= 1'b0;
            end else begin
               flag_q <= flag_d;
            end
         end
         assign flag_out[i] = flag_q;
      end
   endgenerate
endmodule : sxi_w1c_bits
`default_nettype wire

// File: hw/sxi_top.sv
// system exception status, pending requests and last-serviced vector
//
// Summary of operation
// - exceptions raise regardless of master enable, all through one shared vector.
// - on exception push pc and flags, fetch vector 000008h, set status bit.
// - a source whose status bit is set cannot raise again until cleared.
// - a different exception during service vectors again and sets its own bit.
// - illegal instruction pushes pc and flags only once while its bit stands.
// - acknowledge clears the matching pending bit until the next pulse.
// - writing one to a pending bit clears it; zero leaves it.
// - writing one to the set register sets the pending bit.
// - both status bytes readable singly or as one 16-bit access.
// - high status bits 7..3: sp, pc overflow, div zero, div overflow, illegal.
// - divide overflow flagged when the quotient exceeds 0fffffff.
// - low status bits 2..0: watchdog osc fail, primary osc fail, watchdog.
// - taking a vector stores its address bits in the last-serviced register.
// - last-serviced reads bit 7 and bits 1..0 zero, resets to 04h.
// - a request pulse sets its pending bit, held until ack or clear.
// - master enable cleared on ack, reset, trap and every exception.
`timescale 1ns/1ps
`default_nettype none
module sxi_top
   import sxi_pkg::*;
#(
   parameter int NUM_REQ = 8
) (
   input  wire logic                    CLK_SYS_IN,
   input  wire logic                    RESETN_IN,
   // register port
   input  wire logic [sxi_pkg::SXI_ADDR_W-1:0] ADDR_IN,
   input  wire logic [15:0]             WDATA_IN,
   input  wire logic                    WIDE_IN,
   input  wire logic                    WR_IN,
   input  wire logic                    RD_IN,
   output logic      [15:0]             RDATA_OUT,
   // exception events from the core
   input  wire logic                    EXC_SP_OVF_IN,
   input  wire logic                    EXC_PC_OVF_IN,
   input  wire logic                    EXC_ILLEGAL_IN,
   input  wire logic                    EXC_WDT_OSC_IN,
   input  wire logic                    EXC_PRI_OSC_IN,
   input  wire logic                    EXC_WDT_IN,
   input  wire logic                    DIV_VALID_IN,
   input  wire logic [31:0]             DIV_DIVISOR_IN,
   input  wire logic [63:0]             DIV_QUOTIENT_IN,
   // interrupt requests and core handshake
   input  wire logic [NUM_REQ-1:0]      REQ_PULSE_IN,
   input  wire logic                    ACK_IN,
   input  wire logic [sxi_pkg::SXI_VEC_W-1:0] ACK_VEC_IN,
   input  wire logic                    TRAP_IN,
   input  wire logic                    MIE_SET_IN,
   output logic                         MASTER_IRQ_ENABLE_OUT,
   output logic                         IRQ_REQ_OUT,
   output logic                         EXC_TAKE_OUT,
   output logic                         PUSH_CONTEXT_OUT,
   output logic      [23:0]             VECTOR_ADDR_OUT
);
   import sxi_pkg::*;

   // address decode; a wide access at the high byte reaches both status bytes
   wire sel_high = (ADDR_IN == SXI_ADDR_EXC_HIGH);
   wire sel_low  = (ADDR_IN == SXI_ADDR_EXC_LOW) | (sel_high & WIDE_IN);
   wire sel_last = (ADDR_IN == SXI_ADDR_LAST_VEC);
   wire sel_pend = (ADDR_IN == SXI_ADDR_PEND);
   wire sel_pset = (ADDR_IN == SXI_ADDR_PEND_SET);

   // byte lanes: wide access puts high register in [15:8]
   wire [7:0] wr_high_byte = WIDE_IN ? WDATA_IN[15:8] : WDATA_IN[7:0];
   wire [7:0] wr_low_byte  = WDATA_IN[7:0];

   // divide faults derived from the divider result
   wire div_zero = DIV_VALID_IN & (DIV_DIVISOR_IN == 32'h0000_0000);
   wire div_ovf  = DIV_VALID_IN & ~div_zero
                   & (DIV_QUOTIENT_IN > {32'h0000_0000, SXI_QUOT_MAX});

   // raw exception events in status order, high then low byte
   wire [SXI_HIGH_N-1:0] raw_high = {EXC_SP_OVF_IN, EXC_PC_OVF_IN, div_zero,
                                     div_ovf, EXC_ILLEGAL_IN};
   wire [SXI_LOW_N-1:0]  raw_low  = {EXC_WDT_OSC_IN, EXC_PRI_OSC_IN, EXC_WDT_IN};

   wire [SXI_HIGH_N-1:0] st_high;
   wire [SXI_LOW_N-1:0]  st_low;

   // an event from a source already flagged is blocked
   wire [SXI_HIGH_N-1:0] take_high = raw_high & ~st_high;
   wire [SXI_LOW_N-1:0]  take_low  = raw_low & ~st_low;
   // any new type vectors again, even mid-service; enable plays no part
   wire exc_take = (|take_high) | (|take_low);
   // a repeated illegal opcode is masked by its set flag above, so it cannot push twice
   wire exc_push = exc_take;

   // write-one clears; reserved bits are ignored, software keeps them zero
   wire wr_high = WR_IN & sel_high;
   wire wr_low  = WR_IN & sel_low;
   wire [SXI_HIGH_N-1:0] clr_high = {SXI_HIGH_N{wr_high}} & wr_high_byte[7:SXI_HIGH_LSB];
   wire [SXI_LOW_N-1:0]  clr_low  = {SXI_LOW_N{wr_low}} & wr_low_byte[SXI_LOW_N-1:0];

   // status flags
   sxi_w1c_bits #(
      .WIDTH    (SXI_HIGH_N)
   ) u_exc_high (
      .clk_in   (CLK_SYS_IN),
      .rst_n_in (RESETN_IN),
      .set_in   (take_high),
      .clr_in   (clr_high),
      .flag_out (st_high)
   );

   sxi_w1c_bits #(
      .WIDTH    (SXI_LOW_N)
   ) u_exc_low (
      .clk_in   (CLK_SYS_IN),
      .rst_n_in (RESETN_IN),
      .set_in   (take_low),
      .clr_in   (clr_low),
      .flag_out (st_low)
   );

   // pending requests: pulse or software set, cleared by ack or write-one
   logic [NUM_REQ-1:0] pend_q;
   logic [NUM_REQ-1:0] pend_d;
   wire  [NUM_REQ-1:0] pend_set  = REQ_PULSE_IN
                                   | ({NUM_REQ{WR_IN & sel_pset}} & WDATA_IN[NUM_REQ-1:0]);
   wire  [NUM_REQ-1:0] ack_onehot = ACK_IN ? (NUM_REQ'(1) << ACK_VEC_IN) : '0;
   wire  [NUM_REQ-1:0] pend_clr  = ack_onehot
                                   | ({NUM_REQ{WR_IN & sel_pend}} & WDATA_IN[NUM_REQ-1:0]);
   assign pend_d = pend_set | (pend_q & ~pend_clr);

   always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         pend_q <= SXI_PEND_RESET[NUM_REQ-1:0];
      end else begin
         pend_q <= pend_d;
      end
   end

   // master enable: exceptions, ack, trap and reset all drop it
   logic mie_q;
   logic mie_d;
   assign mie_d = (exc_take | ACK_IN | TRAP_IN) ? 1'b0 :
                  (MIE_SET_IN ? 1'b1 : mie_q);

   always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         mie_q <= 1'b0;
      end else begin
         mie_q <= mie_d;
      end
   end

   // last-serviced vector field, software may also write it
   logic [SXI_VEC_W-1:0] last_q;
   logic [SXI_VEC_W-1:0] last_d;
   wire  [SXI_VEC_W-1:0] exc_vec_field = SXI_EXC_VECTOR[SXI_VEC_LSB+SXI_VEC_W-1:SXI_VEC_LSB];
   assign last_d = exc_take ? exc_vec_field :
                   ACK_IN   ? ACK_VEC_IN :
                   (WR_IN & sel_last) ? WDATA_IN[SXI_VEC_LSB+SXI_VEC_W-1:SXI_VEC_LSB] :
                   last_q;

   always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         last_q <= SXI_LAST_RESET[SXI_VEC_LSB+SXI_VEC_W-1:SXI_VEC_LSB];
      end else begin
         last_q <= last_d;
      end
   end

   // read mux; unmapped addresses and reserved bits read zero
   wire [7:0] high_byte = {st_high, 3'b000};
   wire [7:0] low_byte  = {5'b00000, st_low};
   wire [7:0] last_byte = {1'b0, last_q, 2'b00};
   wire [15:0] rd_mux =
      (sel_high & WIDE_IN)  ? {high_byte, low_byte} :
      sel_high              ? {8'h00, high_byte} :
      (ADDR_IN == SXI_ADDR_EXC_LOW) ? {8'h00, low_byte} :
      sel_last              ? {8'h00, last_byte} :
      sel_pend              ? 16'(pend_q) :
      16'h0000;

   // registered outputs; read data valid only the cycle after the strobe
   always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         RDATA_OUT             <= 16'h0000;
         EXC_TAKE_OUT          <= 1'b0;
         PUSH_CONTEXT_OUT      <= 1'b0;
         VECTOR_ADDR_OUT       <= 24'h000000;
         IRQ_REQ_OUT           <= 1'b0;
         MASTER_IRQ_ENABLE_OUT <= 1'b0;
      end else begin
         RDATA_OUT             <= RD_IN ? rd_mux : 16'h0000;
         EXC_TAKE_OUT          <= exc_take;
         PUSH_CONTEXT_OUT      <= exc_push;
         VECTOR_ADDR_OUT       <= exc_take ? SXI_EXC_VECTOR : VECTOR_ADDR_OUT;
         IRQ_REQ_OUT           <= (|pend_d) & mie_d;
         MASTER_IRQ_ENABLE_OUT <= mie_d;
      end
   end
endmodule : sxi_top
`default_nettype wire

// File: bench/sxi_core_model.sv
// behavioural core: acknowledges the block's request after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module sxi_core_model (
   input  wire logic       clk_in,
   input  wire logic       irq_in,
   input  wire logic [4:0] vec_in,
   input  wire logic [3:0] delay_in,
   output logic            ack_out,
   output logic [4:0]      ack_vec_out
);
   // one ack per request, then a pause so the registered request can fall
   initial begin
      ack_out = 1'b0;
      ack_vec_out = 5'h1f;
      forever begin
         @(posedge clk_in);
         if (irq_in) begin
            repeat (delay_in) @(posedge clk_in);
            ack_out <= 1'b1;
            ack_vec_out <= vec_in;
            @(posedge clk_in);
            ack_out <= 1'b0;
            ack_vec_out <= ~vec_in; // released index never shows the stale value
            repeat (2) @(posedge clk_in);
         end
      end
   end
endmodule : sxi_core_model
`default_nettype wire

// File: bench/sxi_properties.sv
// port-level assertions for the exception and irq status block
`timescale 1ns/1ps
`default_nettype none
module sxi_properties
   import sxi_pkg::*;
(
   input wire logic        CLK_SYS_IN,
   input wire logic        RESETN_IN,
   input wire logic        RD_IN,
   input wire logic        ACK_IN,
   input wire logic        TRAP_IN,
   input wire logic        EXC_SP_OVF_IN,
   input wire logic        EXC_PC_OVF_IN,
   input wire logic        EXC_ILLEGAL_IN,
   input wire logic        EXC_WDT_OSC_IN,
   input wire logic        EXC_PRI_OSC_IN,
   input wire logic        EXC_WDT_IN,
   input wire logic        DIV_VALID_IN,
   input wire logic        MASTER_IRQ_ENABLE_OUT,
   input wire logic        IRQ_REQ_OUT,
   input wire logic        EXC_TAKE_OUT,
   input wire logic        PUSH_CONTEXT_OUT,
   input wire logic [23:0] VECTOR_ADDR_OUT,
   input wire logic [15:0] RDATA_OUT
);
   default clocking @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (!RESETN_IN);
   // any exception cause at the inputs this cycle
   wire logic exc_any = EXC_SP_OVF_IN | EXC_PC_OVF_IN | EXC_ILLEGAL_IN | EXC_WDT_OSC_IN
                        | EXC_PRI_OSC_IN | EXC_WDT_IN | DIV_VALID_IN;
   a_take_shared_vec:
      assert property (EXC_TAKE_OUT |-> VECTOR_ADDR_OUT == SXI_EXC_VECTOR) else $error("vector not shared");
   a_vec_held:
      assert property (!EXC_TAKE_OUT |-> $stable(VECTOR_ADDR_OUT)) else $error("vector moved");
   a_take_has_cause:
      assert property (EXC_TAKE_OUT |-> $past(exc_any)) else $error("take without cause");
   a_take_one_cycle:
      assert property (EXC_TAKE_OUT && !exc_any |=> !EXC_TAKE_OUT) else $error("take too long");
   a_push_with_take:
      assert property (PUSH_CONTEXT_OUT == EXC_TAKE_OUT) else $error("push mismatch");
   a_exc_clears_mie:
      assert property (EXC_TAKE_OUT |-> !MASTER_IRQ_ENABLE_OUT) else $error("enable kept on exception");
   a_ack_clears_mie:
      assert property (ACK_IN |=> !MASTER_IRQ_ENABLE_OUT) else $error("enable kept on ack");
   a_trap_clears_mie:
      assert property (TRAP_IN |=> !MASTER_IRQ_ENABLE_OUT) else $error("enable kept on trap");
   a_irq_needs_enable:
      assert property (IRQ_REQ_OUT |-> MASTER_IRQ_ENABLE_OUT) else $error("request without enable");
   a_rdata_idle:
      assert property (!$past(RD_IN) |-> RDATA_OUT == 16'h0000) else $error("read data outside slot");
endmodule : sxi_properties
bind sxi_top sxi_properties u_props (.*);
`default_nettype wire

// File: bench/sxi_top_tb.sv
// self-checking bench for the exception and irq status block
`timescale 1ns/1ps
`default_nettype none
module sxi_top_tb;
   import sxi_pkg::*;
   logic        clk, rst_n, wr, rd, wide, trap, mie_set, div_v, ack, mie, irq, take, push;
   logic [23:0] addr, vaddr;
   logic [15:0] wd, rdata, ex;
   logic [5:0]  ev;
   logic [31:0] dvs;
   logic [63:0] quo;
   logic [7:0]  req, m;
   logic [4:0]  ack_vec, core_vec;
   logic [3:0]  core_dly;
   int          n_mismatch = 0, checks = 0, seed = 32'ha058f69d, i, j;
   sxi_top dut (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wd), .WIDE_IN(wide), .WR_IN(wr),
      .RD_IN(rd), .RDATA_OUT(rdata), .EXC_SP_OVF_IN(ev[0]), .EXC_PC_OVF_IN(ev[1]), .EXC_ILLEGAL_IN(ev[2]),
      .EXC_WDT_OSC_IN(ev[3]), .EXC_PRI_OSC_IN(ev[4]), .EXC_WDT_IN(ev[5]), .DIV_VALID_IN(div_v),
      .DIV_DIVISOR_IN(dvs), .DIV_QUOTIENT_IN(quo), .REQ_PULSE_IN(req), .ACK_IN(ack), .ACK_VEC_IN(ack_vec),
      .TRAP_IN(trap), .MIE_SET_IN(mie_set), .MASTER_IRQ_ENABLE_OUT(mie), .IRQ_REQ_OUT(irq),
      .EXC_TAKE_OUT(take), .PUSH_CONTEXT_OUT(push), .VECTOR_ADDR_OUT(vaddr));
   sxi_core_model core (.clk_in(clk), .irq_in(irq), .vec_in(core_vec), .delay_in(core_dly), .ack_out(ack),
      .ack_vec_out(ack_vec));
   // 10 MHz system clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // status bit of source k within {high,low}
   function automatic logic [15:0] msk(input int k);
      return (k < 5) ? 16'h8000 >> k : 16'h0004 >> (k - 5);
   endfunction : msk
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one strobe cycle; read data is looked at in the slot after the strobe
   task automatic bus(input logic we, input logic [23:0] a, input logic [15:0] d, input logic wi);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wide <= wi;
      wr <= we;
      rd <= !we;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask : bus
   task automatic rd_chk(input logic [23:0] a, input logic wi, input logic [15:0] e);
      bus(1'b0, a, 16'h0000, wi);
      chk(24'(rdata), 24'(e));
   endtask : rd_chk
   // pulse one exception source k; divide sources use the divider inputs
   task automatic fire(input int k, input logic [63:0] q, input logic e);
      @(posedge clk);
      if (k == 2 || k == 3) begin
         div_v <= 1'b1;
         dvs <= (k == 2) ? 32'h0 : 32'h1 + 32'($random(seed) & 255);
         quo <= (k == 2) ? 64'h0 : q;
      end else
         ev[(k < 2) ? k : k - 2] <= 1'b1;
      @(posedge clk);
      ev <= 6'h00;
      div_v <= 1'b0;
      dvs <= $random(seed);
      #1;
      chk(24'({take, push, mie}), 24'({e, e, 1'b0}));
      if (e) chk(vaddr, SXI_EXC_VECTOR);
   endtask : fire
   task automatic ctl(input logic t, input logic s);
      @(posedge clk);
      trap <= t;
      mie_set <= s;
      @(posedge clk);
      trap <= 1'b0;
      mie_set <= 1'b0;
      #1;
      chk(24'(mie), 24'(s));
   endtask : ctl
   // request pulse, optionally with a write-one clear in the same cycle
   task automatic rq(input logic [7:0] r, input logic we, input logic [15:0] d);
      @(posedge clk);
      req <= r;
      addr <= SXI_ADDR_PEND;
      wd <= d;
      wide <= 1'b0;
      wr <= we;
      @(posedge clk);
      req <= 8'h00;
      wr <= 1'b0;
      #1;
   endtask : rq
   initial begin
      {wr, rd, wide, trap, mie_set, div_v, ev, req, addr, wd, dvs, quo, core_vec, core_dly, rst_n} = '0;
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      rd_chk(SXI_ADDR_EXC_HIGH, 1'b1, 16'h0000);
      rd_chk(SXI_ADDR_LAST_VEC, 1'b0, 16'h0004);
      rd_chk(SXI_ADDR_PEND, 1'b0, 16'h0000);
      ctl(1'b0, 1'b1);
      ctl(1'b1, 1'b0);
      ctl(1'b0, 1'b1);
      $display("reset and enable test done");
      ex = 16'h0000;
      for (i = 0; i < 8; i++) begin
         fire(i, 64'h10000000, 1'b1);
         ex |= msk(i);
         rd_chk(SXI_ADDR_EXC_HIGH, 1'b1, ex);
      end
      rd_chk(SXI_ADDR_EXC_HIGH, 1'b0, 16'h00f8);
      rd_chk(SXI_ADDR_EXC_LOW, 1'b0, 16'h0007);
      rd_chk(SXI_ADDR_LAST_VEC, 1'b0, 16'h0008);
      for (i = 0; i < 8; i++)
         fire(i, 64'h10000000, 1'b0);
      bus(1'b1, SXI_ADDR_EXC_HIGH, 16'h0008, 1'b0);
      rd_chk(SXI_ADDR_EXC_HIGH, 1'b1, 16'hf007);
      fire(4, 64'h0, 1'b1);
      bus(1'b1, SXI_ADDR_EXC_HIGH, 16'hf807, 1'b1);
      rd_chk(SXI_ADDR_EXC_HIGH, 1'b1, 16'h0000);
      fire(3, 64'h0fffffff, 1'b0);
      fire(3, 64'h10000000, 1'b1);
      $display("exception test done");
      m = 8'($random(seed)) | 8'h01;
      rq(m, 1'b0, 16'h0000);
      rd_chk(SXI_ADDR_PEND, 1'b0, {8'h00, m});
      bus(1'b1, SXI_ADDR_PEND, 16'h000f, 1'b0);
      rd_chk(SXI_ADDR_PEND, 1'b0, {8'h00, m & 8'hf0});
      bus(1'b1, SXI_ADDR_PEND_SET, 16'h00a5, 1'b0);
      rd_chk(SXI_ADDR_PEND_SET, 1'b0, 16'h0000);
      rq(8'h02, 1'b1, 16'h0002);
      rd_chk(SXI_ADDR_PEND, 1'b0, {8'h00, m & 8'hf0 | 8'ha7});
      bus(1'b1, 24'hffe022, 16'h00ff, 1'b0);
      rd_chk(24'hffe022, 1'b0, 16'h0000);
      // let the core model take two requests, slow or prompt at random
      for (j = 5; j < 8; j += 2) begin
         core_vec = 5'(j);
         core_dly = 4'($random(seed) & 3);
         ctl(1'b0, 1'b1);
         chk(24'(irq), 24'h1);
         for (i = 0; i < 20 && ack !== 1'b1; i++) begin
            @(posedge clk);
            #1;
         end
         if (ack !== 1'b1) begin
            n_mismatch++;
            tally_and_finish;
         end
         repeat (3) @(posedge clk);
         #1;
         chk(24'(mie), 24'h0);
         chk(24'(irq), 24'h0);
         rd_chk(SXI_ADDR_LAST_VEC, 1'b0, 16'(j << 2));
      end
      rd_chk(SXI_ADDR_PEND, 1'b0, {8'h00, (m & 8'hf0 | 8'ha7) & 8'h5f});
      $display("request test done");
      tally_and_finish;
   end
endmodule : sxi_top_tb
`default_nettype wire
